//--- logic/dpll_ctrl_pkg.sv
package dpll_ctrl_pkg;
  // Register byte addresses, word index is a quarter of the address.
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] FREE_RUN_LO_ADDR = 8'h08;
  localparam logic [7:0] FREE_RUN_HI_ADDR = 8'h0C;
  localparam logic [7:0] DEV_LO_ADDR = 8'h10;
  localparam logic [7:0] DEV_HI_ADDR = 8'h14;
  localparam logic [7:0] STEP_ADDR = 8'h18;
  localparam logic [7:0] FB_NUM_LO_ADDR = 8'h1C;
  localparam logic [7:0] FB_NUM_HI_ADDR = 8'h20;
  localparam logic [7:0] AN_NUM_LO_ADDR = 8'h24;
  localparam logic [7:0] AN_NUM_HI_ADDR = 8'h28;
  localparam logic [7:0] EFF_FB_LO_ADDR = 8'h2C;
  localparam logic [7:0] EFF_FB_HI_ADDR = 8'h30;
  localparam logic [7:0] EFF_AN_LO_ADDR = 8'h34;
  localparam logic [7:0] EFF_AN_HI_ADDR = 8'h38;
  localparam logic [7:0] FEED_SIZE_ADDR = 8'h3C;
  localparam logic [7:0] FEED_PERIOD_ADDR = 8'h40;
  // Control bit positions.
  localparam int CTRL_HIST_EN = 0;
  localparam int CTRL_STEER_EN = 1;
  localparam int CTRL_PIN_STEER = 2;
  localparam int CTRL_SOFT_RST = 3;
  localparam int CTRL_DIG_EN = 4;
  localparam int CTRL_LOOP_EN = 5;
  localparam int CTRL_FRAC_MODE = 6;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] FEED_PERIOD_RESET = 32'h0000_0001;
  localparam int NUM_W = 40;
  localparam int DEV_W = 38;
  // State codes visible to software.
  typedef enum logic [4:0] {
    ST_CONFIG = 5'h01,
    ST_FREE_RUN = 5'h02,
    ST_ACQUIRE = 5'h04,
    ST_LOCKED = 5'h08,
    ST_HOLDOVER = 5'h10
  } chan_state_t;
endpackage

//--- logic/dpll_state_and_dco_steering.sv
// Implementation choices: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
// How it works
// - At start, mask defaults load, then overlay values overwrite analog and output settings.
// - Overlay enable is sampled from its pin at start-up; when low, mask settings alone apply.
// - Analog loop follows crystal once start-up loads finish; references stay unqualified in free-run.
// - Reference lost after lock with history on but not yet valid returns to free-run.
// - Any valid reference moves free-run or holdover into acquisition.
// - Wide bandwidth during acquisition, normal bandwidth afterwards.
// - Lock-lost flags go to pins and status; frequency lock starts history averaging.
// - Reference loss with no other valid reference enters holdover.
// - History off: holdover uses the offset word against the digital numerator.
// - History on: free-run until history valid, then averaged history.
// - Holdover entry sets phase-lock-lost; frequency flag frozen until reference returns.
// - Valid reference leaves holdover for acquisition without output disturbance.
// - Soft resets rerun the start-up sequence.
// - Steering acts on digital numerator when closed, analog numerator otherwise with loop enable set.
// - Digital steering only while locked; each step adds or subtracts deviation.
// - Software step: zero raises, one lowers the frequency.
// - Pin trigger rising edge steps; direction pin zero raises, one lowers.
// - Clearing steering enable clears the accumulated digital offset.
// - History off: effective analog numerator is programmed plus offset, readable.
// - History on: offset fed stepwise; new write restarts; done flag on completion.
module dpll_state_and_dco_steering #(
  parameter logic [39:0] OVERLAY_AN_NUM = 40'h00_0000_0000,
  parameter logic [7:0] OVERLAY_OUT_CFG = 8'h00,
  parameter logic [7:0] MASK_OUT_CFG = 8'h00,
  parameter logic [39:0] MASK_AN_NUM = 40'h00_0000_0000
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  input wire logic overlay_enable_i,
  input wire logic xo_valid_i,
  input wire logic ref_valid_i,
  input wire logic freq_lock_i,
  input wire logic phase_lock_i,
  input wire logic acq_done_i,
  input wire logic history_valid_i,
  input wire logic [39:0] history_word_i,
  input wire logic step_trigger_pin_i,
  input wire logic step_direction_pin_i,
  output logic freq_lock_lost_flag_o,
  output logic phase_lock_lost_flag_o,
  output logic wide_bandwidth_o,
  output logic history_average_o,
  output logic ref_qualify_o,
  output logic analog_lock_xo_o,
  output logic [39:0] holdover_word_o,
  output logic [39:0] eff_feedback_num_o,
  output logic [39:0] eff_analog_num_o,
  output logic [7:0] out_cfg_o,
  output logic [4:0] state_o
);
  typedef struct packed {
    dpll_ctrl_pkg::chan_state_t st;
    logic [1:0] cfg_phase;
    logic [31:0] ctrl;
    logic [39:0] free_run;
    logic [37:0] dev;
    logic [39:0] fb_num;
    logic [39:0] an_num;
    logic [39:0] fb_off;
    logic [39:0] an_off;
    logic [39:0] feed_left;
    logic [39:0] feed_size;
    logic [31:0] feed_period;
    logic [31:0] feed_cnt;
    logic feed_done;
    logic overlay_en;
    logic [7:0] out_cfg;
    logic [2:0] trig_sync;
    logic [2:0] dir_sync;
    logic trig_level;
    logic freq_lock_lost_flag;
    logic phase_lock_lost_flag;
    logic [39:0] hold_word;
    logic wide_bw;
    logic hist_avg;
    logic ref_qual;
    logic an_xo;
    logic [39:0] eff_fb;
    logic [39:0] eff_an;
    logic [31:0] rdata;
  } state_t;

  state_t s_reg;
  state_t s_next;

  function automatic logic [39:0] sext38(input logic [37:0] v);
    sext38 = {2'b00, v};
  endfunction

  function automatic logic [39:0] apply_step(input logic [39:0] acc, input logic [37:0] d, input logic down);
    apply_step = down ? acc - sext38(d) : acc + sext38(d);
  endfunction

  logic hist_en;
  logic steer_en;
  logic trig_rise;
  logic trig_dir;
  logic sw_step;
  logic step_now;
  logic step_down;
  logic [39:0] feed_amt;

  assign hist_en = s_reg.ctrl[dpll_ctrl_pkg::CTRL_HIST_EN];
  assign steer_en = s_reg.ctrl[dpll_ctrl_pkg::CTRL_STEER_EN];
  // Only the agreeing second and third stages are trusted, so a glitch shorter than a cycle is ignored.
  assign trig_rise = (s_reg.trig_sync[1] == s_reg.trig_sync[2]) && s_reg.trig_sync[2] && !s_reg.trig_level;
  assign trig_dir = s_reg.dir_sync[2];
  assign sw_step = wr_i && (addr_i == dpll_ctrl_pkg::STEP_ADDR);
  assign step_now = s_reg.ctrl[dpll_ctrl_pkg::CTRL_PIN_STEER] ? trig_rise : sw_step;
  assign step_down = s_reg.ctrl[dpll_ctrl_pkg::CTRL_PIN_STEER] ? trig_dir : wdata_i[0];
  assign feed_amt = (s_reg.feed_left[39] ? (40'h00_0000_0000 - s_reg.feed_left) : s_reg.feed_left)
    > s_reg.feed_size ? (s_reg.feed_left[39] ? 40'h00_0000_0000 - s_reg.feed_size : s_reg.feed_size)
    : s_reg.feed_left;

  always_comb begin
    s_next = s_reg;
    s_next.trig_sync = {s_reg.trig_sync[1:0], step_trigger_pin_i};
    s_next.dir_sync = {s_reg.dir_sync[1:0], step_direction_pin_i};
    if (s_reg.trig_sync[1] == s_reg.trig_sync[2]) begin
      s_next.trig_level = s_reg.trig_sync[2];
    end
    s_next.rdata = 32'h0000_0000;
    // Start-up: mask values first, overlay written over them one cycle later.
    unique case (s_reg.st)
      dpll_ctrl_pkg::ST_CONFIG: begin
        if (s_reg.cfg_phase == 2'd0) begin
          s_next.an_num = MASK_AN_NUM;
          s_next.out_cfg = MASK_OUT_CFG;
          s_next.overlay_en = overlay_enable_i;
          s_next.cfg_phase = 2'd1;
        end else if (s_reg.cfg_phase == 2'd1) begin
          if (s_reg.overlay_en) begin
            s_next.an_num = OVERLAY_AN_NUM;
            s_next.out_cfg = OVERLAY_OUT_CFG;
          end
          s_next.cfg_phase = 2'd2;
        end else if (xo_valid_i) begin
          s_next.st = dpll_ctrl_pkg::ST_FREE_RUN;
        end
      end
      dpll_ctrl_pkg::ST_FREE_RUN: begin
        if (ref_valid_i) begin
          s_next.st = dpll_ctrl_pkg::ST_ACQUIRE;
        end
      end
      dpll_ctrl_pkg::ST_ACQUIRE: begin
        if (!ref_valid_i) begin
          s_next.st = dpll_ctrl_pkg::ST_FREE_RUN;
        end else if (acq_done_i && freq_lock_i) begin
          s_next.st = dpll_ctrl_pkg::ST_LOCKED;
        end
      end
      dpll_ctrl_pkg::ST_LOCKED: begin
        if (!ref_valid_i) begin
          if (hist_en && history_valid_i) begin
            s_next.st = dpll_ctrl_pkg::ST_HOLDOVER;
            s_next.hold_word = history_word_i;
          end else if (hist_en) begin
            s_next.st = dpll_ctrl_pkg::ST_FREE_RUN;
          end else begin
            s_next.st = dpll_ctrl_pkg::ST_HOLDOVER;
            s_next.hold_word = s_reg.free_run;
          end
          if (s_next.st == dpll_ctrl_pkg::ST_HOLDOVER) begin
            s_next.phase_lock_lost_flag = 1'b1;
          end
        end
      end
      dpll_ctrl_pkg::ST_HOLDOVER: begin
        if (ref_valid_i) begin
          s_next.st = dpll_ctrl_pkg::ST_ACQUIRE;
        end
      end
      default: s_next.st = dpll_ctrl_pkg::ST_CONFIG;
    endcase
    // Detector flags track except in holdover, where both flags are frozen.
    if (s_reg.st != dpll_ctrl_pkg::ST_HOLDOVER) begin
      s_next.freq_lock_lost_flag = !freq_lock_i;
      if (s_next.st != dpll_ctrl_pkg::ST_HOLDOVER) begin
        s_next.phase_lock_lost_flag = !phase_lock_i;
      end
    end
    // Steering: digital numerator while locked, analog numerator otherwise when loop enable is set.
    if (!steer_en) begin
      s_next.fb_off = 40'h00_0000_0000;
    end else if (step_now && s_reg.st == dpll_ctrl_pkg::ST_LOCKED) begin
      s_next.fb_off = apply_step(s_reg.fb_off, s_reg.dev, step_down);
    end else if (step_now && s_reg.ctrl[dpll_ctrl_pkg::CTRL_LOOP_EN]) begin
      s_next.an_off = apply_step(s_reg.an_off, s_reg.dev, step_down);
    end
    // Relative analog feeding paces the remainder by size and period.
    if (hist_en && s_reg.feed_left != 40'h00_0000_0000) begin
      if (s_reg.feed_cnt + 32'h0000_0001 >= s_reg.feed_period) begin
        s_next.feed_cnt = 32'h0000_0000;
        s_next.an_off = s_reg.an_off + feed_amt;
        s_next.feed_left = s_reg.feed_left - feed_amt;
        if (s_reg.feed_left == feed_amt) begin
          s_next.feed_done = 1'b1;
        end
      end else begin
        s_next.feed_cnt = s_reg.feed_cnt + 32'h0000_0001;
      end
    end
    if (wr_i) begin
      unique case (addr_i)
        dpll_ctrl_pkg::CTRL_ADDR: s_next.ctrl = wdata_i;
        dpll_ctrl_pkg::FREE_RUN_LO_ADDR: s_next.free_run[31:0] = wdata_i;
        dpll_ctrl_pkg::FREE_RUN_HI_ADDR: begin
          s_next.free_run[39:32] = wdata_i[7:0];
          if (hist_en) begin
            s_next.feed_left = {wdata_i[7:0], s_reg.free_run[31:0]};
            s_next.feed_cnt = 32'h0000_0000;
            s_next.feed_done = 1'b0;
          end
        end
        dpll_ctrl_pkg::DEV_LO_ADDR: s_next.dev[31:0] = wdata_i;
        dpll_ctrl_pkg::DEV_HI_ADDR: s_next.dev[37:32] = wdata_i[5:0];
        dpll_ctrl_pkg::FB_NUM_LO_ADDR: s_next.fb_num[31:0] = wdata_i;
        dpll_ctrl_pkg::FB_NUM_HI_ADDR: s_next.fb_num[39:32] = wdata_i[7:0];
        dpll_ctrl_pkg::AN_NUM_LO_ADDR: s_next.an_num[31:0] = wdata_i;
        dpll_ctrl_pkg::AN_NUM_HI_ADDR: s_next.an_num[39:32] = wdata_i[7:0];
        dpll_ctrl_pkg::FEED_SIZE_ADDR: s_next.feed_size = {8'h00, wdata_i};
        dpll_ctrl_pkg::FEED_PERIOD_ADDR: s_next.feed_period = wdata_i;
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
    if (rd_i) begin
      unique case (addr_i)
        dpll_ctrl_pkg::CTRL_ADDR: s_next.rdata = s_reg.ctrl;
        dpll_ctrl_pkg::STATUS_ADDR: s_next.rdata = {23'h00_0000, s_reg.overlay_en, s_reg.feed_done,
          s_reg.phase_lock_lost_flag, s_reg.freq_lock_lost_flag, s_reg.st};
        dpll_ctrl_pkg::FREE_RUN_LO_ADDR: s_next.rdata = s_reg.free_run[31:0];
        dpll_ctrl_pkg::FREE_RUN_HI_ADDR: s_next.rdata = {24'h00_0000, s_reg.free_run[39:32]};
        dpll_ctrl_pkg::DEV_LO_ADDR: s_next.rdata = s_reg.dev[31:0];
        dpll_ctrl_pkg::DEV_HI_ADDR: s_next.rdata = {26'h000_0000, s_reg.dev[37:32]};
        dpll_ctrl_pkg::FB_NUM_LO_ADDR: s_next.rdata = s_reg.fb_num[31:0];
        dpll_ctrl_pkg::FB_NUM_HI_ADDR: s_next.rdata = {24'h00_0000, s_reg.fb_num[39:32]};
        dpll_ctrl_pkg::AN_NUM_LO_ADDR: s_next.rdata = s_reg.an_num[31:0];
        dpll_ctrl_pkg::AN_NUM_HI_ADDR: s_next.rdata = {24'h00_0000, s_reg.an_num[39:32]};
        dpll_ctrl_pkg::EFF_FB_LO_ADDR: s_next.rdata = eff_feedback_num_o[31:0];
        dpll_ctrl_pkg::EFF_FB_HI_ADDR: s_next.rdata = {24'h00_0000, eff_feedback_num_o[39:32]};
        dpll_ctrl_pkg::EFF_AN_LO_ADDR: s_next.rdata = eff_analog_num_o[31:0];
        dpll_ctrl_pkg::EFF_AN_HI_ADDR: s_next.rdata = {24'h00_0000, eff_analog_num_o[39:32]};
        dpll_ctrl_pkg::FEED_SIZE_ADDR: s_next.rdata = s_reg.feed_size[31:0];
        dpll_ctrl_pkg::FEED_PERIOD_ADDR: s_next.rdata = s_reg.feed_period;
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end
    // Soft reset holds the channel in start-up and reruns it on release.
    if (s_reg.ctrl[dpll_ctrl_pkg::CTRL_SOFT_RST]) begin
      s_next.st = dpll_ctrl_pkg::ST_CONFIG;
      s_next.cfg_phase = 2'd0;
    end
    s_next.wide_bw = (s_next.st == dpll_ctrl_pkg::ST_ACQUIRE);
    s_next.hist_avg = s_next.ctrl[dpll_ctrl_pkg::CTRL_HIST_EN] && !s_next.freq_lock_lost_flag && (s_next.st == dpll_ctrl_pkg::ST_LOCKED);
    s_next.ref_qual = (s_next.st != dpll_ctrl_pkg::ST_FREE_RUN) && (s_next.st != dpll_ctrl_pkg::ST_CONFIG);
    s_next.an_xo = (s_next.st != dpll_ctrl_pkg::ST_CONFIG) || (s_next.cfg_phase == 2'd2);
    s_next.eff_fb = s_next.fb_num + s_next.fb_off;
    s_next.eff_an = s_next.an_num + (s_next.ctrl[dpll_ctrl_pkg::CTRL_HIST_EN] ? s_next.an_off
      : s_next.free_run + s_next.an_off);
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
      s_reg.st <= dpll_ctrl_pkg::ST_CONFIG;
      s_reg.ctrl <= dpll_ctrl_pkg::CTRL_RESET;
      s_reg.overlay_en <= 1'b0;
      s_reg.feed_period <= dpll_ctrl_pkg::FEED_PERIOD_RESET;
      s_reg.freq_lock_lost_flag <= 1'b1;
      s_reg.phase_lock_lost_flag <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Every output is a register field, so the sums settle a cycle early instead of rippling to the pins.
  always_comb begin
    rdata_o = s_reg.rdata;
    freq_lock_lost_flag_o = s_reg.freq_lock_lost_flag;
    phase_lock_lost_flag_o = s_reg.phase_lock_lost_flag;
    wide_bandwidth_o = s_reg.wide_bw;
    history_average_o = s_reg.hist_avg;
    ref_qualify_o = s_reg.ref_qual;
    analog_lock_xo_o = s_reg.an_xo;
    holdover_word_o = s_reg.hold_word;
    eff_feedback_num_o = s_reg.eff_fb;
    eff_analog_num_o = s_reg.eff_an;
    out_cfg_o = s_reg.out_cfg;
    state_o = s_reg.st;
  end

  AST_HOLD_SETS_PHASE_LOCK_LOST_FLAG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st != dpll_ctrl_pkg::ST_HOLDOVER && s_next.st == dpll_ctrl_pkg::ST_HOLDOVER) |=> s_reg.phase_lock_lost_flag)
    else $error("Phase lock lost flag not set on holdover entry.");
  AST_FREQ_LOCK_LOST_FLAG_FROZEN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st == dpll_ctrl_pkg::ST_HOLDOVER && $past(s_reg.st) == dpll_ctrl_pkg::ST_HOLDOVER) |-> $stable(s_reg.freq_lock_lost_flag))
    else $error("Frequency flag changed in holdover.");
  AST_REF_LEAVES: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st == dpll_ctrl_pkg::ST_FREE_RUN && ref_valid_i && !s_reg.ctrl[3]) |=> s_reg.st == dpll_ctrl_pkg::ST_ACQUIRE)
    else $error("Free-run not left on valid reference.");
  AST_NO_HIST_FREE_RUN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st == dpll_ctrl_pkg::ST_LOCKED && !ref_valid_i && hist_en && !history_valid_i && !s_reg.ctrl[3])
    |=> s_reg.st == dpll_ctrl_pkg::ST_FREE_RUN)
    else $error("Lost reference without history did not go to free-run.");
  AST_STEER_CLEAR: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !steer_en |=> eff_feedback_num_o == s_reg.fb_num)
    else $error("Offset not cleared with steering disabled.");
  AST_STEP_SIGN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (steer_en && step_now && !step_down && s_reg.st == dpll_ctrl_pkg::ST_LOCKED)
    |=> s_reg.fb_off == $past(s_reg.fb_off) + sext38($past(s_reg.dev)))
    else $error("Upward step did not add deviation.");
  AST_WIDE_BW: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    wide_bandwidth_o |-> s_reg.st == dpll_ctrl_pkg::ST_ACQUIRE)
    else $error("Wide bandwidth outside acquisition.");
  AST_SOFT_RESTART: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    s_reg.ctrl[dpll_ctrl_pkg::CTRL_SOFT_RST] |=> s_reg.st == dpll_ctrl_pkg::ST_CONFIG ##1 s_reg.cfg_phase != 2'd3)
    else $error("Soft reset did not restart.");

  // The checks below mix registered state with live inputs; AST_FEED_DONE excludes a bus write in the same cycle.
  AST_FREE_RUN_UNQUAL: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st == dpll_ctrl_pkg::ST_FREE_RUN) |-> !ref_qualify_o)
    else $error("Reference qualified in free-run.");
  AST_XO_LOCK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st == dpll_ctrl_pkg::ST_CONFIG && s_reg.cfg_phase == 2'd2 && xo_valid_i && !s_reg.ctrl[3])
    |=> s_reg.st == dpll_ctrl_pkg::ST_FREE_RUN)
    else $error("Start-up did not end on valid crystal.");
  AST_OVERLAY_LOAD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st == dpll_ctrl_pkg::ST_CONFIG && s_reg.cfg_phase == 2'd1 && s_reg.overlay_en && !s_reg.ctrl[3])
    |=> out_cfg_o == OVERLAY_OUT_CFG)
    else $error("Overlay did not replace mask output settings.");
  AST_HOLD_NO_HIST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st == dpll_ctrl_pkg::ST_LOCKED && !ref_valid_i && !hist_en && !s_reg.ctrl[3])
    |=> s_reg.st == dpll_ctrl_pkg::ST_HOLDOVER && holdover_word_o == $past(s_reg.free_run))
    else $error("Holdover without history did not use offset word.");
  AST_HOLD_HIST: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st == dpll_ctrl_pkg::ST_LOCKED && !ref_valid_i && hist_en && history_valid_i && !s_reg.ctrl[3])
    |=> s_reg.st == dpll_ctrl_pkg::ST_HOLDOVER && holdover_word_o == $past(history_word_i))
    else $error("Holdover with valid history did not use history.");
  AST_HOLD_EXIT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st == dpll_ctrl_pkg::ST_HOLDOVER && ref_valid_i && !s_reg.ctrl[3]) |=> s_reg.st == dpll_ctrl_pkg::ST_ACQUIRE)
    else $error("Holdover not left on valid reference.");
  AST_PHASE_LOCK_LOST_FLAG_IN_HOLD: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st == dpll_ctrl_pkg::ST_HOLDOVER) |-> phase_lock_lost_flag_o)
    else $error("Phase lock lost flag low in holdover.");
  AST_ACQ_TO_LOCK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st == dpll_ctrl_pkg::ST_ACQUIRE && ref_valid_i && acq_done_i && freq_lock_i && !s_reg.ctrl[3])
    |=> s_reg.st == dpll_ctrl_pkg::ST_LOCKED && !wide_bandwidth_o)
    else $error("Acquisition did not end in lock with normal bandwidth.");
  AST_FLOCK_TRACK: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (s_reg.st != dpll_ctrl_pkg::ST_HOLDOVER) |=> freq_lock_lost_flag_o == !$past(freq_lock_i))
    else $error("Frequency lock lost flag does not follow detector.");
  AST_HIST_AVG: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    history_average_o |-> hist_en && !s_reg.freq_lock_lost_flag && s_reg.st == dpll_ctrl_pkg::ST_LOCKED)
    else $error("History averaging outside frequency lock.");
  AST_STEP_DOWN: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (steer_en && step_now && step_down && s_reg.st == dpll_ctrl_pkg::ST_LOCKED)
    |=> s_reg.fb_off == $past(s_reg.fb_off) - sext38($past(s_reg.dev)))
    else $error("Downward step did not subtract deviation.");
  AST_STEER_LOCK_ONLY: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (steer_en && s_reg.st != dpll_ctrl_pkg::ST_LOCKED) |=> $stable(s_reg.fb_off))
    else $error("Digital offset changed while not locked.");
  AST_EFF_AN_ABS: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !hist_en |-> eff_analog_num_o == s_reg.an_num + s_reg.free_run + s_reg.an_off)
    else $error("Effective analog numerator is not numerator plus offset.");
  AST_FEED_DONE: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (hist_en && s_reg.feed_left != 40'h00_0000_0000 && s_reg.feed_left == feed_amt && !wr_i
    && s_reg.feed_cnt + 32'h0000_0001 >= s_reg.feed_period) |=> s_reg.feed_done)
    else $error("Feed done flag not set on last step.");
  AST_STATE_ONEHOT: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $onehot(s_reg.st))
    else $error("Channel state code is not one-hot.");
endmodule

//--- dv/dpll_host_model.sv
`timescale 1ns/10ps
module dpll_host_model (
  input wire logic clk_i,
  input wire logic [31:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [31:0] wdata_o,
  output logic wr_o,
  output logic rd_o,
  output logic trig_o,
  output logic dir_o
);
  initial begin
    addr_o = 8'h00;
    wdata_o = 32'h0000_0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
    trig_o = 1'b0;
    dir_o = 1'b0;
  end
  // The address is inverted after each access, the write data after each write, so no stale value is mistaken for a request.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    d = rdata_i;
  endtask
  // Pulses stay 120 ns high and 120 ns low, so width and rate keep their limits.
  task automatic pin_step(input logic dn);
    @(posedge clk_i);
    dir_o <= dn;
    repeat (12) @(posedge clk_i);
    trig_o <= 1'b1;
    repeat (12) @(posedge clk_i);
    trig_o <= 1'b0;
    repeat (12) @(posedge clk_i);
  endtask
endmodule

//--- dv/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic clk_i, rst_n_i, wr_i, rd_i, overlay_enable_i, xo_valid_i, ref_valid_i;
  logic freq_lock_i, phase_lock_i, acq_done_i, history_valid_i, step_trigger_pin_i, step_direction_pin_i;
  logic [7:0] addr_i, out_cfg_o;
  logic [31:0] wdata_i, rdata_o;
  logic [39:0] history_word_i, holdover_word_o, eff_feedback_num_o, eff_analog_num_o;
  logic freq_lock_lost_flag_o, phase_lock_lost_flag_o, wide_bandwidth_o, history_average_o;
  logic ref_qualify_o, analog_lock_xo_o;
  logic [4:0] state_o;
  int err_count, num_checks;
  // Digital enable, analog loop and fraction mode on, as the host must set them for steering.
  localparam logic [31:0] MODE = 32'h0000_0070;
  dpll_state_and_dco_steering #(.OVERLAY_AN_NUM(40'h00_0000_2000), .OVERLAY_OUT_CFG(8'hA5),
    .MASK_OUT_CFG(8'h5A), .MASK_AN_NUM(40'h00_0000_1000)) dpll_state_and_dco_steering_i (
    .clk_i, .rst_n_i, .addr_i, .wdata_i, .wr_i, .rd_i, .rdata_o, .overlay_enable_i, .xo_valid_i,
    .ref_valid_i, .freq_lock_i, .phase_lock_i, .acq_done_i, .history_valid_i, .history_word_i,
    .step_trigger_pin_i, .step_direction_pin_i, .freq_lock_lost_flag_o, .phase_lock_lost_flag_o,
    .wide_bandwidth_o, .history_average_o, .ref_qualify_o, .analog_lock_xo_o, .holdover_word_o,
    .eff_feedback_num_o, .eff_analog_num_o, .out_cfg_o, .state_o);
  dpll_host_model dpll_host_model_i (.clk_i, .rdata_i(rdata_o), .addr_o(addr_i), .wdata_o(wdata_i),
    .wr_o(wr_i), .rd_o(rd_i), .trig_o(step_trigger_pin_i), .dir_o(step_direction_pin_i));
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (err_count == 0 && num_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wst(input logic [4:0] s);
    int n;
    n = 0;
    while (state_o !== s && n < 60) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    chk(state_o, s);
  endtask
  task automatic w40(input logic [7:0] a, input logic [39:0] v);
    dpll_host_model_i.wr(a, v[31:0]);
    dpll_host_model_i.wr(a + 8'h04, {24'h00_0000, v[39:32]});
  endtask
  task automatic r40(input logic [7:0] a, output logic [39:0] v);
    logic [31:0] lo;
    logic [31:0] hi;
    dpll_host_model_i.rd(a, lo);
    dpll_host_model_i.rd(a + 8'h04, hi);
    v = {hi[7:0], lo};
  endtask
  task automatic relock();
    @(posedge clk_i);
    acq_done_i <= 1'b0;
    freq_lock_i <= 1'b1;
    ref_valid_i <= 1'b1;
    wst(dpll_ctrl_pkg::ST_ACQUIRE);
    chk(wide_bandwidth_o, 1'b1);
    chk(ref_qualify_o, 1'b1);
    @(posedge clk_i);
    acq_done_i <= 1'b1;
    wst(dpll_ctrl_pkg::ST_LOCKED);
    chk(wide_bandwidth_o, 1'b0);
  endtask
  task automatic lose_ref();
    @(posedge clk_i);
    ref_valid_i <= 1'b0;
  endtask
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    err_count++;
    report_and_stop();
  end
  initial begin
    logic [39:0] fb, dev, fr, an, eff, rv40;
    logic [31:0] rv;
    logic d;
    logic dirs[$];
    {rst_n_i, overlay_enable_i, xo_valid_i, ref_valid_i, freq_lock_i} = 5'b00000;
    {phase_lock_i, acq_done_i, history_valid_i} = 3'b000;
    history_word_i = 40'h00_0000_0000;
    err_count = 0;
    num_checks = 0;
    void'($urandom(59116));
    fb = 40'({$urandom(), $urandom()});
    dev = {2'b00, 38'({$urandom(), $urandom()})};
    fr = 40'({$urandom(), $urandom()});
    an = 40'({$urandom(), $urandom()});
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    chk(state_o, dpll_ctrl_pkg::ST_CONFIG);
    chk({freq_lock_lost_flag_o, phase_lock_lost_flag_o}, 2'b11);
    dpll_host_model_i.rd(dpll_ctrl_pkg::STATUS_ADDR, rv);
    chk(rv[8], 1'b0);
    chk(out_cfg_o, 8'h5A);
    @(posedge clk_i);
    xo_valid_i <= 1'b1;
    phase_lock_i <= 1'b1;
    wst(dpll_ctrl_pkg::ST_FREE_RUN);
    chk({analog_lock_xo_o, ref_qualify_o}, 2'b10);
    chk(eff_analog_num_o, 40'h00_0000_1000);
    dpll_host_model_i.rd(8'hFC, rv);
    chk(rv, 32'h0000_0000);
    w40(dpll_ctrl_pkg::AN_NUM_LO_ADDR, an);
    w40(dpll_ctrl_pkg::FREE_RUN_LO_ADDR, fr);
    dpll_host_model_i.wr(dpll_ctrl_pkg::CTRL_ADDR, MODE);
    r40(dpll_ctrl_pkg::EFF_AN_LO_ADDR, rv40);
    chk(rv40, an + fr);
    chk(eff_analog_num_o, an + fr);
    relock();
    repeat (4) @(posedge clk_i);
    chk({freq_lock_lost_flag_o, phase_lock_lost_flag_o}, 2'b00);
    w40(dpll_ctrl_pkg::FB_NUM_LO_ADDR, fb);
    w40(dpll_ctrl_pkg::DEV_LO_ADDR, dev);
    dpll_host_model_i.wr(dpll_ctrl_pkg::CTRL_ADDR, MODE | 32'h0000_0002);
    eff = fb;
    for (int i = 0; i < 4; i++) begin
      d = 1'($urandom_range(1, 0));
      dpll_host_model_i.wr(dpll_ctrl_pkg::STEP_ADDR, {31'h0000_0000, d});
      @(posedge clk_i);
      #1;
      eff = d ? eff - dev : eff + dev;
      chk(eff_feedback_num_o, eff);
    end
    dpll_host_model_i.wr(dpll_ctrl_pkg::CTRL_ADDR, MODE | 32'h0000_0006);
    dirs = '{1'b0, 1'b1, 1'b1};
    foreach (dirs[k]) begin
      dpll_host_model_i.pin_step(dirs[k]);
      eff = dirs[k] ? eff - dev : eff + dev;
      chk(eff_feedback_num_o, eff);
    end
    dpll_host_model_i.wr(dpll_ctrl_pkg::CTRL_ADDR, MODE);
    @(posedge clk_i);
    #1;
    chk(eff_feedback_num_o, fb);
    lose_ref();
    wst(dpll_ctrl_pkg::ST_HOLDOVER);
    chk(holdover_word_o, fr);
    chk(phase_lock_lost_flag_o, 1'b1);
    @(posedge clk_i);
    freq_lock_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    chk(freq_lock_lost_flag_o, 1'b0);
    relock();
    dpll_host_model_i.wr(dpll_ctrl_pkg::CTRL_ADDR, MODE | 32'h0000_0001);
    repeat (3) @(posedge clk_i);
    #1;
    chk(history_average_o, 1'b1);
    lose_ref();
    wst(dpll_ctrl_pkg::ST_FREE_RUN);
    relock();
    @(posedge clk_i);
    history_valid_i <= 1'b1;
    history_word_i <= 40'({$urandom(), $urandom()});
    lose_ref();
    wst(dpll_ctrl_pkg::ST_HOLDOVER);
    chk(holdover_word_o, history_word_i);
    dpll_host_model_i.wr(dpll_ctrl_pkg::CTRL_ADDR, MODE | 32'h0000_0008);
    wst(dpll_ctrl_pkg::ST_CONFIG);
    dpll_host_model_i.wr(dpll_ctrl_pkg::CTRL_ADDR, 32'h0000_0000);
    wst(dpll_ctrl_pkg::ST_FREE_RUN);
    dpll_host_model_i.wr(dpll_ctrl_pkg::FEED_SIZE_ADDR, 32'h0000_0010);
    dpll_host_model_i.wr(dpll_ctrl_pkg::FEED_PERIOD_ADDR, 32'h0000_0003);
    dpll_host_model_i.wr(dpll_ctrl_pkg::CTRL_ADDR, MODE | 32'h0000_0001);
    fr = 40'($urandom_range(255, 1));
    w40(dpll_ctrl_pkg::FREE_RUN_LO_ADDR, fr);
    repeat (60) @(posedge clk_i);
    #1;
    chk(eff_analog_num_o, 40'h00_0000_1000 + fr);
    dpll_host_model_i.rd(dpll_ctrl_pkg::STATUS_ADDR, rv);
    chk(rv[7], 1'b1);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    overlay_enable_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_n_i <= 1'b1;
    wst(dpll_ctrl_pkg::ST_FREE_RUN);
    chk(out_cfg_o, 8'hA5);
    chk(eff_analog_num_o, 40'h00_0000_2000);
    dpll_host_model_i.rd(dpll_ctrl_pkg::STATUS_ADDR, rv);
    chk(rv[8], 1'b1);
    report_and_stop();
  end
endmodule
